// >>> hw/tdr_pkg.sv
// Purpose: Constants for the three-state four-bit D register with APB control
// Assumes: One clock, clk at 100 MHz; APB with 32-bit data and byte addresses
// Notes:   Software bits only add to the pin controls, never override them
package tdr_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Datapath
  localparam int          TDR_DATA_BITS      = 4;
  localparam int          TDR_MAX_DATA_BITS  = 16;

  //////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses
  localparam logic [31:0] TDR_CTRL_ADDR      = 32'h0000_0000;
  localparam logic [31:0] TDR_STATUS_ADDR    = 32'h0000_0004;

  // Control register fields
  localparam int          TDR_CTRL_BITS      = 3;
  localparam int          TDR_CTRL_HOLD_BIT  = 0;
  localparam int          TDR_CTRL_OFF_BIT   = 1;
  localparam int          TDR_CTRL_CLR_BIT   = 2;
  localparam logic [2:0]  TDR_CTRL_RESET     = 3'h0;

  // Status register fields: stored bits sit at bit 0 upward
  localparam int          TDR_STAT_DRIVE_BIT = 16;

  typedef logic [31:0] tdr_word_t;

endpackage : tdr_pkg

// >>> hw/tdr_top.sv
// Purpose: Four-bit D register with gated load, direct clear and releasable outputs
// Assumes: Pin inputs synchronous to clk except clear, which acts at once
// Notes:   Output enables follow the output controls one clock later
//
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module tdr_top #(
  parameter int DATA_BITS = tdr_pkg::TDR_DATA_BITS
) (
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire logic                 clear,
  input  wire logic                 load_gate_a_n,
  input  wire logic                 load_gate_b_n,
  input  wire logic                 out_ctrl_m,
  input  wire logic                 out_ctrl_n,
  input  wire logic [DATA_BITS-1:0] data_in,
  output logic      [DATA_BITS-1:0] q_out,
  output logic      [DATA_BITS-1:0] q_oe,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire tdr_pkg::tdr_word_t   paddr,
  input  wire tdr_pkg::tdr_word_t   pwdata,
  input  wire logic [3:0]           pstrb,
  output logic                      pready,
  output tdr_pkg::tdr_word_t        prdata,
  output logic                      pslverr
);
  import tdr_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Parameter check
  if (DATA_BITS < 1 || DATA_BITS > TDR_MAX_DATA_BITS) begin : g_bad_width
    $error("DATA_BITS out of range");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Decoding helpers
  function automatic logic tdr_load_ok(input logic ga_n, input logic gb_n, input logic hold);
    tdr_load_ok = !ga_n && !gb_n && !hold;
  endfunction : tdr_load_ok

  function automatic logic tdr_addr_ok(input tdr_word_t addr);
    tdr_addr_ok = (addr == TDR_CTRL_ADDR) || (addr == TDR_STATUS_ADDR);
  endfunction : tdr_addr_ok

  logic [TDR_CTRL_BITS-1:0] ctrl;
  logic [TDR_CTRL_BITS-1:0] next_ctrl;
  logic [DATA_BITS-1:0]     next_q_out;
  logic [DATA_BITS-1:0]     next_q_oe;
  logic                     next_pready;
  tdr_word_t                next_prdata;
  logic                     next_pslverr;
  logic                     load;
  logic                     sw_clear;
  logic                     release_bus;
  logic                     setup;
  logic                     write_done;

  //////////////////////////////////////////////////////////////////////////////
  // Storage: one flip-flop per bit
  assign load        = tdr_load_ok(load_gate_a_n, load_gate_b_n, ctrl[TDR_CTRL_HOLD_BIT]);
  assign sw_clear    = ctrl[TDR_CTRL_CLR_BIT];
  assign release_bus = out_ctrl_m || out_ctrl_n || ctrl[TDR_CTRL_OFF_BIT];

  // Each bit has its own data path; only the controls are shared
  for (genvar gi = 0; gi < DATA_BITS; gi++) begin : g_bit
    always_comb begin
      if (sw_clear) begin
        next_q_out[gi] = 1'b0;
      end else if (load) begin
        next_q_out[gi] = data_in[gi];
      end else begin
        next_q_out[gi] = q_out[gi];
      end
    end
  end

  // Clear bypasses the clock so it acts without waiting for an edge
  always_ff @(posedge clk or posedge clear) begin
    if (clear) begin
      q_out <= '0;
    end else if (!reset_n) begin
      q_out <= '0;
    end else begin
      q_out <= next_q_out;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output enables, independent of the storage path
  always_comb begin
    next_q_oe = release_bus ? '0 : '1;
  end

  // Enables reset off so nothing fights the bus at power-up
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      q_oe <= '0;
    end else begin
      q_oe <= next_q_oe;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // APB slave: zero-wait, answer in the first access cycle
  // Error answers never commit, so a bad address cannot reach the control bits
  assign setup      = psel && !penable;
  assign write_done = psel && penable && pready && pwrite && !pslverr;

  always_comb begin
    next_pready  = setup;
    next_pslverr = setup && !tdr_addr_ok(paddr);
    next_prdata  = prdata;
    // Read data is built at setup, so it already stands in the access cycle
    if (setup && !pwrite) begin
      next_prdata = '0;
      if (paddr == TDR_CTRL_ADDR) begin
        next_prdata[TDR_CTRL_BITS-1:0] = ctrl;
      end else if (paddr == TDR_STATUS_ADDR) begin
        next_prdata[DATA_BITS-1:0]       = q_out;
        next_prdata[TDR_STAT_DRIVE_BIT]  = q_oe[0];
      end
    end
    // Only the lowest byte lane carries control bits; other lanes are ignored
    next_ctrl = ctrl;
    if (write_done && paddr == TDR_CTRL_ADDR && pstrb[0]) begin
      next_ctrl = pwdata[TDR_CTRL_BITS-1:0];
    end
  end

  // Bus registers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctrl    <= TDR_CTRL_RESET;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      ctrl    <= next_ctrl;
      pready  <= next_pready;
      pslverr <= next_pslverr;
      prdata  <= next_prdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Assertions; clear is direct so checks pause while it is high
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n || clear);

  for (genvar ai = 0; ai < DATA_BITS; ai++) begin : g_chk
    bit_own_a: assert property (
      load && !sw_clear |=> q_out[ai] == $past(data_in[ai]))
      else $error("bit did not take its own data input");
  end

  load_capture_a: assert property (
    !load_gate_a_n && !load_gate_b_n && !ctrl[TDR_CTRL_HOLD_BIT] && !sw_clear |=> q_out == $past(data_in))
    else $error("load with both gates low did not capture data");

  gate_hold_a: assert property (
    (load_gate_a_n || load_gate_b_n) && !sw_clear |=> $stable(q_out))
    else $error("stored bits changed while a load gate was high");

  steady_hold_a: assert property (
    !$stable(q_out) |-> $past(load || sw_clear))
    else $error("stored bits changed without load or clear");

  clear_prio_a: assert property (
    sw_clear |=> q_out == '0)
    else $error("clear did not win over load");

  drive_on_a: assert property (
    !out_ctrl_m && !out_ctrl_n && !ctrl[TDR_CTRL_OFF_BIT] |=> q_oe == '1)
    else $error("outputs not driven with both controls low");

  drive_off_a: assert property (
    (out_ctrl_m || out_ctrl_n) [*2] |-> q_oe == '0)
    else $error("outputs driven while an output control was high");

  hiz_load_a: assert property (
    (out_ctrl_m || out_ctrl_n) && load && !sw_clear |=> q_out == $past(data_in) && q_oe == '0)
    else $error("released outputs disturbed the flip-flops");

  apb_answer_a: assert property (
    setup |=> pready ##1 !pready)
    else $error("APB answer not a single access cycle");

  //////////////////////////////////////////////////////////////////////////////
  // Reset and direct clear; these must see through their own disable
  // Reset leaves every output and the control bits at rest
  reset_state_a: assert property (
    disable iff (1'b0)
    !reset_n |=> q_oe == '0 && !pready && !pslverr && prdata == '0 && ctrl == TDR_CTRL_RESET)
    else $error("reset left outputs or control set");

  // Direct clear already shows at the first edge it is seen
  clear_low_a: assert property (
    disable iff (!reset_n)
    clear |-> q_out == '0)
    else $error("stored bits not low while clear was high");

  // Nothing may load in the edge that ends the clear
  clear_release_a: assert property (
    disable iff (!reset_n)
    $fell(clear) |-> q_out == '0)
    else $error("stored bits not low as clear ended");

  //////////////////////////////////////////////////////////////////////////////
  // Software controls add to the pins
  // Software hold blocks loading like a gate
  sw_hold_a: assert property (
    ctrl[TDR_CTRL_HOLD_BIT] && !sw_clear |=> $stable(q_out))
    else $error("stored bits changed under software hold");

  // Software release acts like an output control
  sw_off_a: assert property (
    ctrl[TDR_CTRL_OFF_BIT] |=> q_oe == '0)
    else $error("outputs driven under software release");

  // All enables move as one
  oe_together_a: assert property (
    q_oe == '0 || q_oe == '1)
    else $error("output enables split");

  // Clearing still works with the outputs released
  hiz_clear_a: assert property (
    (out_ctrl_m || out_ctrl_n) && sw_clear |=> q_out == '0)
    else $error("clear lost while outputs released");

  // Holding still works with the outputs released
  hiz_hold_a: assert property (
    (out_ctrl_m || out_ctrl_n) && !load && !sw_clear |=> $stable(q_out))
    else $error("hold lost while outputs released");

  //////////////////////////////////////////////////////////////////////////////
  // Register bus
  // No answer without a setup cycle before it
  apb_idle_a: assert property (
    !setup |=> !pready)
    else $error("APB answer without setup");

  // Unmapped addresses answer with an error
  apb_err_a: assert property (
    setup && !tdr_addr_ok(paddr) |=> pready && pslverr)
    else $error("APB error missing for unmapped address");

  // Mapped addresses answer cleanly
  apb_ok_a: assert property (
    setup && tdr_addr_ok(paddr) |=> !pslverr)
    else $error("APB error on mapped address");

  // A committed write lands in the control bits
  ctrl_write_a: assert property (
    write_done && paddr == TDR_CTRL_ADDR && pstrb[0] |=> ctrl == $past(pwdata[TDR_CTRL_BITS-1:0]))
    else $error("control write did not land");

  // Control bits move only on a committed write
  ctrl_keep_a: assert property (
    !write_done |=> $stable(ctrl))
    else $error("control changed without a write");

  // A write with the low lane off is dropped
  strb_skip_a: assert property (
    psel && penable && pready && pwrite && !pstrb[0] |=> $stable(ctrl))
    else $error("control written with low lane off");

  // A write answered with an error is dropped
  err_skip_a: assert property (
    psel && penable && pready && pwrite && pslverr |=> $stable(ctrl))
    else $error("control written by an error transfer");

  // Control read back as stored
  rd_ctrl_a: assert property (
    setup && !pwrite && paddr == TDR_CTRL_ADDR |=> prdata[TDR_CTRL_BITS-1:0] == $past(ctrl))
    else $error("control read wrong");

  // Status shows the stored bits
  rd_status_a: assert property (
    setup && !pwrite && paddr == TDR_STATUS_ADDR |=> prdata[DATA_BITS-1:0] == $past(q_out))
    else $error("status bits read wrong");

  // Status shows whether the outputs drive
  rd_drive_a: assert property (
    setup && !pwrite && paddr == TDR_STATUS_ADDR |=> prdata[TDR_STAT_DRIVE_BIT] == $past(q_oe[0]))
    else $error("status drive flag read wrong");

  // Unmapped reads return zero
  rd_err_a: assert property (
    setup && !pwrite && !tdr_addr_ok(paddr) |=> prdata == '0)
    else $error("unmapped read not zero");

  // Read data stands until the next read setup
  prdata_hold_a: assert property (
    !(setup && !pwrite) |=> $stable(prdata))
    else $error("read data moved without a read");

  apb_err_c:   cover property (setup && !tdr_addr_ok(paddr) ##1 pslverr);
  load_hold_c: cover property (load ##1 !load && !sw_clear ##1 $stable(q_out));
  hiz_load_c:  cover property (q_oe == '0 && load ##1 q_out != $past(q_out));
  sw_clear_c:  cover property (sw_clear && load ##1 q_out == '0);
  apb_write_c: cover property (write_done ##1 ctrl != $past(ctrl));

endmodule : tdr_top

// >>> tb/tdr_bus_peer.sv
// Purpose: Other driver on the shared data bus
// Assumes: Bench enables it only while the register is released
// Notes:   No pull-up, so a floating line flips every cycle
`timescale 1ns/1ps
module tdr_bus_peer (
  input  wire logic       clk,
  input  wire logic [3:0] q_out,
  input  wire logic [3:0] q_oe,
  input  wire logic       peer_oe,
  input  wire logic [3:0] peer_val,
  output logic      [3:0] bus,
  output logic            clash
);
  logic [3:0] last = 4'h0;
  // Line level from both drivers; a floating line must not look stable
  assign bus = (q_oe & q_out) | (~q_oe & (peer_oe ? peer_val : ~last));
  assign clash = peer_oe & (|q_oe);
  // Remember the last level
  always_ff @(posedge clk) begin
    last <= bus;
  end
endmodule : tdr_bus_peer

// >>> tb/tristate_4bit_d_register_tb_top.sv
// Purpose: Self-checking bench for the four-bit register
// Assumes: Zero-wait APB, one-clock lag on loads and enables
// Notes:   All stimulus on the rising edge
`timescale 1ns/1ps
module tristate_4bit_d_register_tb_top;
  import tdr_pkg::*;
  logic       clk = 1'b0, reset_n = 1'b0, clear = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic       load_gate_a_n = 1'b0, load_gate_b_n = 1'b0, out_ctrl_m = 1'b0, out_ctrl_n = 1'b0;
  logic       peer_oe = 1'b0, pready, pslverr, clash, e;
  logic [3:0] data_in = 4'h0, peer_val = 4'h0, pstrb = 4'hF, q_out, q_oe, bus;
  tdr_word_t  paddr = 32'h0, pwdata = 32'h0, prdata, rd;
  int         err_count = 0, n_checks = 0, cycles = 0;
  tdr_top i_tdr_top (.clk(clk), .reset_n(reset_n), .clear(clear), .load_gate_a_n(load_gate_a_n),
    .load_gate_b_n(load_gate_b_n), .out_ctrl_m(out_ctrl_m), .out_ctrl_n(out_ctrl_n), .data_in(data_in),
    .q_out(q_out), .q_oe(q_oe), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr));
  tdr_bus_peer i_tdr_bus_peer (.clk(clk), .q_out(q_out), .q_oe(q_oe), .peer_oe(peer_oe),
    .peer_val(peer_val), .bus(bus), .clash(clash));
  //////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      close_out();
    end
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask : step
  // Pin controls change together just after an edge
  task automatic pins(input logic a, input logic b, input logic m, input logic n, input logic [3:0] d);
    @(posedge clk);
    load_gate_a_n <= a;
    load_gate_b_n <= b;
    out_ctrl_m <= m;
    out_ctrl_n <= n;
    data_in <= d;
  endtask : pins
  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input tdr_word_t a, input tdr_word_t d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  //////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_load();
    pins(1'b0, 1'b0, 1'b0, 1'b0, 4'hA);
    #1 chk(q_out, 4'h0);
    step(1);
    #1 chk(q_out, 4'hA);
    pins(1'b0, 1'b0, 1'b0, 1'b0, 4'h5);
    step(1);
    #1 chk(q_out, 4'h5);
    chk(bus, 4'h5);
    $display("load test done");
  endtask : t_load
  task automatic t_hold();
    pins(1'b1, 1'b0, 1'b0, 1'b0, 4'h3);
    step(1);
    #1 chk(q_out, 4'h5);
    pins(1'b0, 1'b1, 1'b0, 1'b0, 4'hC);
    step(1);
    #1 chk(q_out, 4'h5);
    apb(1'b1, TDR_CTRL_ADDR, 32'h1);
    pins(1'b0, 1'b0, 1'b0, 1'b0, 4'h9);
    step(2);
    apb(1'b0, TDR_STATUS_ADDR, 32'h0);
    chk(rd, 32'h0001_0005);
    apb(1'b1, TDR_CTRL_ADDR, 32'h0);
    apb(1'b0, 32'h0000_0008, 32'h0);
    chk({rd[30:0], e}, 32'h1);
    $display("hold test done");
  endtask : t_hold
  task automatic t_clear();
    step(2);
    #1 chk(q_out, 4'h9);
    @(posedge clk);
    clear <= 1'b1;
    #1 chk(q_out, 4'h0);
    step(1);
    #1 chk(q_out, 4'h0);
    @(posedge clk);
    clear <= 1'b0;
    $display("clear test done");
  endtask : t_clear
  task automatic t_float();
    pins(1'b0, 1'b0, 1'b1, 1'b0, 4'h6);
    step(1);
    #1 chk(q_oe, 4'h0);
    chk(q_out, 4'h6);
    @(posedge clk);
    peer_oe <= 1'b1;
    peer_val <= 4'h9;
    #1 chk(bus, 4'h9);
    chk(clash, 1'b0);
    @(posedge clk);
    peer_oe <= 1'b0;
    pins(1'b0, 1'b0, 1'b0, 1'b1, 4'h3);
    step(1);
    #1 chk(q_oe, 4'h0);
    pins(1'b0, 1'b0, 1'b0, 1'b0, 4'h3);
    step(1);
    #1 chk(q_oe, 4'hF);
    chk(bus, 4'h3);
    $display("release test done");
  endtask : t_float
  // Software release, software clear, dropped lane and a second reset
  task automatic t_soft();
    apb(1'b1, TDR_CTRL_ADDR, 32'h2);
    step(1);
    #1 chk(q_oe, 4'h0);
    pins(1'b0, 1'b0, 1'b0, 1'b0, 4'hC);
    step(1);
    #1 chk(q_out, 4'hC);
    apb(1'b1, TDR_CTRL_ADDR, 32'h4);
    step(1);
    #1 chk(q_out, 4'h0);
    chk(q_oe, 4'hF);
    @(posedge clk);
    pstrb <= 4'hE;
    apb(1'b1, TDR_CTRL_ADDR, 32'h0);
    pstrb <= 4'hF;
    apb(1'b0, TDR_CTRL_ADDR, 32'h0);
    chk(rd, 32'h4);
    @(posedge clk);
    reset_n <= 1'b0;
    step(2);
    reset_n <= 1'b1;
    #1 chk(q_oe, 4'h0);
    apb(1'b0, TDR_CTRL_ADDR, 32'h0);
    chk(rd, 32'h0);
    $display("software control test done");
  endtask : t_soft
  initial begin
    step(6);
    reset_n <= 1'b1;
    t_load();
    t_hold();
    t_clear();
    t_float();
    t_soft();
    close_out();
  end
endmodule : tristate_4bit_d_register_tb_top
